// file: design/sensor_host_pkg.sv
// constants and types shared by the sensor host port
package sensor_host_pkg;
	localparam int CLK_NS = 10;
	localparam int I2C_BIT_NS = 2500;
	localparam int SPI_BIT_NS = 1000;
	// quarter bit rounded up so the bit never runs faster than allowed
	localparam int I2C_QTR_CYC = (I2C_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam int SPI_QTR_CYC = (SPI_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam int TICK_W = 7;
	localparam int STARTUP_NS = 100000;
	localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_W = 24;
	localparam logic [5:0] ADDR_HI = 6'h34;
	localparam logic RW_READ = 1'h1;
	localparam logic RW_WRITE = 1'h0;
	localparam logic [3:0] I2C_LAST_BIT = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'h7;
	localparam logic [1:0] STG_ADDR_W = 2'h0;
	localparam logic [1:0] STG_INDEX = 2'h1;
	localparam logic [1:0] STG_ADDR_R = 2'h2;
	localparam logic [1:0] STG_DATA = 2'h3;
	localparam logic [6:0] CFG_INDEX = 7'h00;
	localparam logic [7:0] CFG_DISABLE = 8'h10;
	localparam logic [11:0] SPI_MIN_EDGES = 12'h010;
	typedef enum logic [4:0] {
		ST_WAIT = 5'h01,
		ST_IDLE = 5'h02,
		ST_START = 5'h04,
		ST_BYTE = 5'h08,
		ST_STOP = 5'h10
	} state_t;
endpackage : sensor_host_pkg

// file: design/pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= {WIDTH{1'h1}};
			q <= {WIDTH{1'h1}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : pin_sync
`default_nettype wire

// file: design/quarter_tick.sv
// quarter-bit tick divider for the host-made link clock
`timescale 1ns/1ps
`default_nettype none
module quarter_tick
	import sensor_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic spi,
	output logic tick
);
	logic [TICK_W-1:0] cnt;
	logic [TICK_W-1:0] limit;

	assign limit = spi ? TICK_W'(SPI_QTR_CYC - 1) : TICK_W'(I2C_QTR_CYC - 1);

	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			cnt <= '0;
			tick <= 1'h0;
		end else if (cnt == limit) begin
			cnt <= '0;
			tick <= 1'h1;
		end else begin
			cnt <= cnt + TICK_W'(1);
			tick <= 1'h0;
		end
	end
endmodule : quarter_tick
`default_nettype wire

// file: design/sensor_host_port.sv
// host controller driving the sensor over two-wire or four-wire link
`timescale 1ns/1ps
`default_nettype none
module sensor_host_port
	import sensor_host_pkg::*;
#(
	parameter int unsigned STARTUP_COUNT = STARTUP_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_mode,
	input wire logic addr_lsb_select_pin,
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_index,
	input wire logic [7:0] cmd_count,
	output logic cmd_ready,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic nack,
	output logic init_done,
	output logic scl_out,
	output logic scl_oe,
	input wire logic scl_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic sda_in,
	output logic spi_clk,
	output logic spi_cs_n,
	output logic serial_in_line,
	input wire logic serial_out_line
);
	state_t state;
	logic mode_spi;
	logic is_read;
	logic init_xfer;
	logic pend;
	logic got_ack;
	logic [1:0] q;
	logic [1:0] stage;
	logic [3:0] bitn;
	logic [6:0] index;
	logic [7:0] left;
	logic [7:0] shreg;
	logic [WAIT_W-1:0] wait_cnt;
	logic [2:0] sync_q;
	logic scl_s;
	logic sda_s;
	logic miso_s;
	logic tick;
	logic running;
	logic hold_clk;
	logic adv;
	logic sample;
	logic tx_byte;
	logic drive;
	logic [3:0] last_bit;
	logic next_scl_oe;
	logic next_sda_oe;
	logic next_sclk;
	logic next_cs_n;
	logic next_mosi;

	pin_sync #(
		.WIDTH(3)
	) i_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({scl_in, sda_in, serial_out_line}),
		.q(sync_q)
	);

	assign scl_s = sync_q[2];
	assign sda_s = sync_q[1];
	assign miso_s = sync_q[0];

	quarter_tick i_quarter_tick (
		.clk(clk),
		.rst_n(rst_n),
		.clear(!running),
		.spi(mode_spi),
		.tick(tick)
	);

	assign running = (state == ST_START) || (state == ST_BYTE) ||
		(state == ST_STOP);
	assign last_bit = mode_spi ? SPI_LAST_BIT : I2C_LAST_BIT;
	// a stretched clock freezes the quarter phase, not the divider
	assign hold_clk = !mode_spi && (q == 2'h1) && !scl_s;
	assign adv = tick && !pend && !hold_clk;
	// two-wire data sampled with SCL high, four-wire after the rise
	assign sample = adv && (state == ST_BYTE) &&
		(mode_spi ? (q == 2'h2) : (q == 2'h1));
	assign tx_byte = !((stage == STG_DATA) && is_read);
	// ninth bit: we ack read bytes except the last, which gets NACK
	assign drive = (bitn == I2C_LAST_BIT) ?
		(!tx_byte && (left != 8'h01)) :
		(tx_byte && !shreg[7]);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= 2'h0;
		end else if (!running) begin
			q <= 2'h0;
		end else if (adv) begin
			q <= q + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_WAIT;
			mode_spi <= 1'h0;
			is_read <= 1'h0;
			init_xfer <= 1'h0;
			pend <= 1'h0;
			got_ack <= 1'h0;
			stage <= STG_ADDR_W;
			bitn <= 4'h0;
			index <= 7'h00;
			left <= 8'h00;
			shreg <= 8'h00;
			wait_cnt <= '0;
			cmd_ready <= 1'h0;
			wr_ready <= 1'h0;
			rd_valid <= 1'h0;
			rd_data <= 8'h00;
			done <= 1'h0;
			nack <= 1'h0;
			init_done <= 1'h0;
		end else begin
			wr_ready <= 1'h0;
			rd_valid <= 1'h0;
			done <= 1'h0;
			case (state)
			ST_WAIT: begin
				mode_spi <= spi_mode;
				if (!spi_mode) begin
					state <= ST_IDLE;
					cmd_ready <= 1'h1;
					init_done <= 1'h1;
				end else if (wait_cnt == WAIT_W'(STARTUP_COUNT)) begin
					// first access turns the two-wire port off
					state <= ST_START;
					init_xfer <= 1'h1;
					is_read <= 1'h0;
					index <= CFG_INDEX;
					left <= 8'h01;
					stage <= STG_INDEX;
					shreg <= {RW_WRITE, CFG_INDEX};
					bitn <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + WAIT_W'(1);
				end
			end
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					state <= ST_START;
					cmd_ready <= 1'h0;
					nack <= 1'h0;
					is_read <= cmd_read;
					index <= cmd_index;
					left <= (cmd_count == 8'h00) ? 8'h01 : cmd_count;
					bitn <= 4'h0;
					pend <= 1'h0;
					if (mode_spi) begin
						stage <= STG_INDEX;
						shreg <= {cmd_read, cmd_index};
					end else begin
						stage <= STG_ADDR_W;
						shreg <= {ADDR_HI, addr_lsb_select_pin,
							RW_WRITE};
					end
				end
			end
			ST_START: begin
				if (adv && (q == 2'h3)) begin
					state <= ST_BYTE;
				end
			end
			ST_BYTE: begin
				// the bus waits with SCL low until a write byte arrives
				if (pend && (init_xfer || wr_valid)) begin
					shreg <= init_xfer ? CFG_DISABLE : wr_data;
					pend <= 1'h0;
					wr_ready <= !init_xfer;
				end
				if (sample) begin
					if (bitn == I2C_LAST_BIT) begin
						got_ack <= !sda_s;
					end else begin
						shreg <= {shreg[6:0],
							mode_spi ? miso_s : sda_s};
					end
				end
				if (adv && (q == 2'h3)) begin
					if (bitn != last_bit) begin
						bitn <= bitn + 4'h1;
					end else begin
						bitn <= 4'h0;
						if (!mode_spi && tx_byte && !got_ack) begin
							nack <= 1'h1;
							state <= ST_STOP;
						end else begin
							case (stage)
							STG_ADDR_W: begin
								stage <= STG_INDEX;
								shreg <= {1'h0, index};
							end
							STG_INDEX: begin
								if (is_read && !mode_spi) begin
									// repeated start, then read address
									stage <= STG_ADDR_R;
									state <= ST_START;
									shreg <= {ADDR_HI, addr_lsb_select_pin,
										RW_READ};
								end else begin
									stage <= STG_DATA;
									pend <= !is_read;
								end
							end
							STG_ADDR_R: begin
								stage <= STG_DATA;
							end
							default: begin
								if (is_read) begin
									rd_valid <= 1'h1;
									rd_data <= shreg;
								end
								left <= left - 8'h01;
								if (left == 8'h01) begin
									state <= ST_STOP;
								end else begin
									pend <= !is_read;
								end
							end
							endcase
						end
					end
				end
			end
			ST_STOP: begin
				if (adv && (q == 2'h3)) begin
					state <= ST_IDLE;
					cmd_ready <= 1'h1;
					done <= !init_xfer;
					init_done <= 1'h1;
					init_xfer <= 1'h0;
				end
			end
			default: begin
				state <= ST_WAIT;
			end
			endcase
		end
	end

	// desired pin levels per state and quarter, registered below
	always_comb begin
		next_scl_oe = 1'h0;
		next_sda_oe = 1'h0;
		next_sclk = 1'h0;
		next_cs_n = 1'h1;
		next_mosi = serial_in_line;
		if (mode_spi) begin
			next_cs_n = !running ||
				((state == ST_STOP) && (q == 2'h3));
			next_sclk = (state == ST_BYTE) && q[1];
			if ((state == ST_BYTE) && (q == 2'h0)) begin
				next_mosi = shreg[7];
			end
		end else begin
			case (state)
			ST_START: begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				next_sda_oe = q[1];
			end
			ST_BYTE: begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				next_sda_oe = (q == 2'h0) ? drive : sda_oe;
			end
			ST_STOP: begin
				next_scl_oe = (q == 2'h0);
				next_sda_oe = !q[1];
			end
			default: begin
				next_scl_oe = 1'h0;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_out <= 1'h0;
			sda_out <= 1'h0;
			scl_oe <= 1'h0;
			sda_oe <= 1'h0;
			spi_clk <= 1'h0;
			spi_cs_n <= 1'h1;
			serial_in_line <= 1'h0;
		end else begin
			scl_out <= 1'h0;
			sda_out <= 1'h0;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			spi_clk <= next_sclk;
			spi_cs_n <= next_cs_n;
			serial_in_line <= next_mosi;
		end
	end

	// rising clock edges per select frame, only for checking
	logic sclk_d;
	logic [11:0] edge_cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_d <= 1'h0;
			edge_cnt <= 12'h000;
		end else begin
			sclk_d <= spi_clk;
			if (spi_cs_n) begin
				edge_cnt <= 12'h000;
			end else if (spi_clk && !sclk_d) begin
				edge_cnt <= edge_cnt + 12'h001;
			end
		end
	end

	start_cond_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && $rose(sda_oe) && !scl_oe |-> $past(state) == ST_START)
		else $error("sda fell with scl high outside a start");

	stop_cond_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && $fell(sda_oe) && !scl_oe |-> $past(state) == ST_STOP)
		else $error("sda rose with scl high outside a stop");

	sda_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && $past(state) == ST_BYTE && !scl_oe && $past(!scl_oe)
		|-> $stable(sda_oe))
		else $error("sda moved while scl high in a byte");

	stretch_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && running && q == 2'h1 && !scl_s |=> q == 2'h1)
		else $error("clock phase advanced while scl held low");

	ack_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && state == ST_BYTE && bitn == 4'h8 && q == 2'h0
		&& !tx_byte && left > 8'h01 |=> sda_oe)
		else $error("no ack driven on a read byte");

	nack_last_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && state == ST_BYTE && bitn == 4'h8 && q == 2'h0
		&& !tx_byte && left == 8'h01 |=> !sda_oe)
		else $error("last read byte not left unacknowledged");

	addr_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_spi && state == ST_BYTE && bitn == 4'h0 && q == 2'h0
		&& (stage == STG_ADDR_W || stage == STG_ADDR_R)
		|-> shreg == {ADDR_HI, addr_lsb_select_pin, stage == STG_ADDR_R})
		else $error("address byte malformed");

	spi_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_spi && state == ST_BYTE && stage == STG_INDEX
		&& bitn == 4'h0 && q == 2'h0 && !pend |-> shreg == {is_read, index})
		else $error("command byte malformed");

	spi_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_spi && $changed(serial_in_line) |-> !spi_clk)
		else $error("serial data changed with clock high");

	cs_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_spi && $past(state) == ST_BYTE |-> !spi_cs_n)
		else $error("select high during a byte");

	spi_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(spi_cs_n) |-> edge_cnt >= SPI_MIN_EDGES
		&& edge_cnt[2:0] == 3'h0)
		else $error("access shorter than two whole bytes");
endmodule : sensor_host_port
`default_nettype wire

// file: verif/sensor_model.sv
// behavioural sensor: two-wire and four-wire slave over a register space
`timescale 1ns/1ps
`default_nettype none
module sensor_model
	import sensor_host_pkg::*;
(
	input wire logic scl,
	input wire logic sda,
	input wire logic strap,
	input wire logic slow,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	output logic scl_pull,
	output logic sda_pull,
	output logic miso
);
	logic [7:0] regs [128];
	logic [7:0] sh, tx, ssh, stx;
	logic [6:0] idx, sidx;
	logic act, sel, rw, mack, drv, srw, sbit;
	int rcv, stg, sn;
	initial begin
		for (int i = 0; i < 128; i++) regs[i] = {1'b1, 7'(i)};
		{scl_pull, sda_pull, act, drv, sbit, sel} = '0;
		sn = 0;
	end
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1;
		rcv = 0;
		stg = 0;
		drv = 0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		act = 0;
		sda_pull = 0;
	end
	always @(posedge scl) if (act) begin
		if (rcv < 8) sh = {sh[6:0], sda};
		else mack = !sda;
		rcv++;
	end
	always @(negedge scl) if (act) begin
		if (rcv == 8) begin
			sda_pull = 0;
			drv = 0;
			if (stg == 0) begin
				sel = sh[7:1] == {ADDR_HI, strap};
				rw = sh[0];
				sda_pull = sel;
				stg = 1;
			end else if (sel && !rw) begin
				if (stg == 1) idx = sh[6:0];
				else begin
					regs[idx] = sh;
					idx++;
				end
				sda_pull = 1;
				stg = 2;
			end
		end else if (rcv == 9) begin
			rcv = 0;
			sda_pull = 0;
			if (sel && rw && mack) begin
				tx = regs[idx];
				idx++;
				drv = 1;
				sda_pull = !tx[7];
			end
			// longer than two quarters, so the host really has to wait
			if (slow) begin
				scl_pull = 1;
				#3000 scl_pull = 0;
			end
		end else if (drv) sda_pull = !tx[3'(7 - rcv)];
	end
	always @(negedge cs_n) sn = 0;
	always @(posedge sck) if (!cs_n) begin
		ssh = {ssh[6:0], mosi};
		sn++;
		if (sn == 8) {srw, sidx} = ssh;
		else if (sn % 8 == 0 && !srw) begin
			regs[sidx] = ssh;
			sidx++;
		end
	end
	always @(negedge sck) if (!cs_n && srw && sn >= 8) begin
		if (sn % 8 == 0) begin
			stx = regs[sidx];
			sidx++;
		end
		sbit = stx[3'(7 - sn % 8)];
	end
	// deselected: inverse of last bit, so a host that samples it is caught
	assign miso = cs_n ? !sbit : sbit;
endmodule : sensor_model
`default_nettype wire

// file: verif/sensor_host_port_test.sv
// self-checking bench for the sensor host port against a sensor model
`timescale 1ns/1ps
`default_nettype none
module sensor_host_port_test
	import sensor_host_pkg::*;
;
	localparam int LIMIT = 90000;
	logic clk = 0, rst_n = 0, spi_mode = 0, pin = 1, strap = 1, slow = 0;
	logic cmd_valid = 0, cmd_read = 0, wr_valid = 0;
	logic [6:0] cmd_index = '0;
	logic [7:0] cmd_count = '0, wr_data = '0, rd_data;
	logic cmd_ready, wr_ready, rd_valid, done, nack, init_done;
	logic scl_oe, sda_oe, spi_clk, spi_cs_n, scl_pull, sda_pull;
	logic serial_in_line, serial_out_line, scl_out, sda_out;
	wire logic scl = !(scl_oe || scl_pull);
	wire logic sda = !(sda_oe || sda_pull);
	logic [7:0] shadow [128];
	int mismatches = 0, checks_done = 0, cycles = 0;
	always #5 clk = ~clk;
	// short start-up wait keeps the run brief
	sensor_host_port #(.STARTUP_COUNT(20)) i_sensor_host_port (
		.clk(clk), .rst_n(rst_n), .spi_mode(spi_mode),
		.addr_lsb_select_pin(pin), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_index(cmd_index), .cmd_count(cmd_count),
		.cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.done(done), .nack(nack), .init_done(init_done), .scl_out(scl_out),
		.scl_oe(scl_oe), .scl_in(scl), .sda_out(sda_out), .sda_oe(sda_oe),
		.sda_in(sda), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.serial_in_line(serial_in_line), .serial_out_line(serial_out_line)
	);
	sensor_model i_sensor_model (
		.scl(scl), .sda(sda), .strap(strap), .slow(slow), .cs_n(spi_cs_n),
		.sck(spi_clk), .mosi(serial_in_line), .scl_pull(scl_pull),
		.sda_pull(sda_pull), .miso(serial_out_line)
	);
	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic do_reset(input logic mode);
		int t;
		rst_n = 0;
		spi_mode = mode;
		repeat (20) @(negedge clk);
		check("sda_oe", sda_oe, 0);
		check("spi_cs_n", spi_cs_n, 1);
		rst_n = 1;
		for (t = 0; t < 5000 && init_done !== 1'b1; t++) @(negedge clk);
		check("init_done", init_done, 1);
		check("scl_out", scl_out, 0);
		check("sda_out", sda_out, 0);
	endtask : do_reset
	// entered at a falling edge; leaves at the falling edge showing done
	task automatic xfer(input logic rd, input logic [6:0] idx, input int n,
			input logic [7:0] base, input int expn);
		int k, got, t;
		k = 0;
		got = 0;
		cmd_valid = 1;
		cmd_read = rd;
		cmd_index = idx;
		cmd_count = 8'(n);
		wr_valid = !rd;
		wr_data = base;
		// done of the previous call may still show at entry, so step first
		for (t = 0; t < 40000; t++) begin
			@(negedge clk);
			if (cmd_ready === 1'b0) cmd_valid = 0;
			if (wr_ready === 1'b1) begin
				k++;
				wr_data = base + 8'(k);
				wr_valid = k < n;
			end
			if (rd_valid === 1'b1) begin
				check("rd_data", rd_data, shadow[7'(idx + got)]);
				got++;
			end
			if (done === 1'b1) break;
		end
		wr_valid = 0;
		check("byte count", 8'(k + got), 8'(expn));
		check("done", done, 1);
	endtask : xfer
	task automatic wr_chk(input logic [6:0] idx, input int n,
			input logic [7:0] base);
		xfer(0, idx, n, base, n);
		for (int i = 0; i < n; i++) begin
			shadow[7'(idx + i)] = base + 8'(i);
			check("reg", i_sensor_model.regs[7'(idx + i)],
				shadow[7'(idx + i)]);
		end
		check("nack", nack, 0);
	endtask : wr_chk
	task automatic t_i2c;
		slow = 1;
		wr_chk(7'h05, 3, 8'h3C);
		slow = 0;
		xfer(1, 7'h04, 4, 8'h00, 4);
		check("sda idle", sda, 1);
		check("scl idle", scl, 1);
		strap = 0;
		xfer(0, 7'h09, 1, 8'h55, 0);
		check("nack", nack, 1);
		check("reg", i_sensor_model.regs[9], shadow[9]);
		strap = 1;
		xfer(1, 7'h09, 1, 8'h00, 1);
		check("nack", nack, 0);
		$display("test two_wire done");
	endtask : t_i2c
	task automatic t_spi;
		check("cfg", i_sensor_model.regs[CFG_INDEX], CFG_DISABLE);
		shadow[CFG_INDEX] = CFG_DISABLE;
		wr_chk(7'h20, 3, 8'hC1);
		check("cs idle", spi_cs_n, 1);
		check("clk idle", spi_clk, 0);
		xfer(1, CFG_INDEX, 1, 8'h00, 1);
		xfer(1, 7'h1F, 4, 8'h00, 4);
		$display("test four_wire done");
	endtask : t_spi
	initial begin
		for (int i = 0; i < 128; i++) shadow[i] = {1'b1, 7'(i)};
		@(negedge clk);
		do_reset(0);
		t_i2c();
		do_reset(1);
		t_spi();
		final_report();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			final_report();
		end
	end
endmodule : sensor_host_port_test
`default_nettype wire
